// ### caf_pkg.sv
package caf_pkg;

   // ---------------------------------------------------------------
   // Sizes of the filter bank.
   // ---------------------------------------------------------------
   localparam int NUM_FILTERS = 16;
   localparam int NUM_CTRL = 4;
   localparam int PTR_W = 5;
   localparam int SID_W = 11;
   localparam int EID_W = 18;

   // ---------------------------------------------------------------
   // Register map: byte addresses, the word index is the address over four.
   // ---------------------------------------------------------------
   // Control pairs: low at 0x00 + 8*x, high at 0x04 + 8*x, x = 0..3.
   localparam logic [11:0] CTRL_BASE = 12'h000;
   // Identifier pairs: low at 0x40 + 8*x, high at 0x44 + 8*x.
   localparam logic [11:0] FOBJ_BASE = 12'h040;
   // Mask pairs: low at 0xc0 + 8*x, high at 0xc4 + 8*x.
   localparam logic [11:0] MASK_BASE = 12'h0c0;
   // Data-byte filtering mode control word.
   localparam logic [11:0] MODE_ADDR = 12'h140;
   // Last match result status word.
   localparam logic [11:0] STAT_ADDR = 12'h144;

   // ---------------------------------------------------------------
   // Field positions inside the 16-bit words.
   // ---------------------------------------------------------------
   localparam int CTL_EN_BIT = 7;
   localparam int HI_SEL_BIT = 14;
   localparam int HI_FILTER_STANDARD_ID_BIT11_BIT = 13;
   localparam int LO_EID_LSB = 11;
   localparam int RESET_VAL = 0;

   // Writable bits of each word; other bits read as zero.
   localparam logic [15:0] CTL_MASK = 16'h9f9f;
   localparam logic [15:0] HI_MASK = 16'h7fff;
   localparam logic [15:0] LO_MASK = 16'hffff;

endpackage : caf_pkg

// ### caf_filter.sv
// Register access over APB and the placing of the registers were decided locally.
module caf_filter
(
   input wire logic sys_clk,
   input wire logic reset,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Received frame from the protocol engine.
   input wire logic rx_valid,
   input wire logic rx_extended,
   input wire logic [10:0] rx_standard_id,
   input wire logic [17:0] rx_extended_id,
   input wire logic [15:0] rx_data_bytes,
   // Acceptance result, one cycle after rx_valid.
   output logic accept_valid,
   output logic accept_hit,
   output logic [4:0] accept_object,
   output logic [3:0] accept_filter
);

   // ---------------------------------------------------------------
   // Storage.
   // ---------------------------------------------------------------
   // Control bytes, one per filter: enable at bit 7, pointer at 4:0.
   logic [7:0] filter_ctrl [caf_pkg::NUM_FILTERS];
   // Identifier high and low words per filter.
   logic [15:0] fobj_hi [caf_pkg::NUM_FILTERS];
   logic [15:0] fobj_lo [caf_pkg::NUM_FILTERS];
   // Mask high and low words per filter.
   logic [15:0] mask_hi [caf_pkg::NUM_FILTERS];
   logic [15:0] mask_lo [caf_pkg::NUM_FILTERS];
   // Data-byte filtering mode enable.
   logic data_byte_mode;
   // Count of frames accepted, for status readback.
   logic [15:0] hit_count;

   // Decoded access fields.
   logic wr_en;
   logic [3:0] idx;
   logic is_hi;
   logic [15:0] wdata16;
   logic in_ctrl;
   logic in_fobj;
   logic in_mask;

   // ---------------------------------------------------------------
   // Address decode.
   // ---------------------------------------------------------------
   // True when the address falls in the half-open span from lo up to
   // but not including hi. The identifier and mask banks start on
   // 8-byte but not 128-byte boundaries, so a plain compare of upper
   // address bits would alias them onto other words of the map.
   function automatic logic in_span(input logic [11:0] a,
      input logic [11:0] lo, input logic [11:0] hi);
      in_span = (a >= lo) && (a < hi);
   endfunction : in_span

   // Filter number inside a bank of sixteen 8-byte word pairs.
   function automatic logic [3:0] bank_index(input logic [11:0] a,
      input logic [11:0] base);
      logic [11:0] offset;
      offset = a - base;
      bank_index = offset[6:3];
   endfunction : bank_index

   // Every access completes in its first access cycle, so pready is
   // simply the access phase itself; no wait states are ever added.
   assign pready = psel && penable;
   assign wr_en = psel && penable && pwrite;
   assign is_hi = paddr[2];
   assign wdata16 = pwdata[15:0];
   assign in_ctrl = (paddr[11:5] == caf_pkg::CTRL_BASE[11:5]);
   // The identifier bank ends where the mask bank begins, and the mask
   // bank ends at the mode word.
   assign in_fobj = in_span(paddr, caf_pkg::FOBJ_BASE, caf_pkg::MASK_BASE);
   assign in_mask = in_span(paddr, caf_pkg::MASK_BASE, caf_pkg::MODE_ADDR);
   // One index serves both banks, picked by the bank addressed.
   assign idx = in_mask ? bank_index(paddr, caf_pkg::MASK_BASE) :
      bank_index(paddr, caf_pkg::FOBJ_BASE);

   // True for any word-aligned address inside the map.
   function automatic logic addr_mapped(input logic [11:0] a);
      addr_mapped = (a[1:0] == 2'h0) &&
         ((a[11:5] == caf_pkg::CTRL_BASE[11:5]) ||
          in_span(a, caf_pkg::FOBJ_BASE, caf_pkg::MODE_ADDR) ||
          (a == caf_pkg::MODE_ADDR) || (a == caf_pkg::STAT_ADDR));
   endfunction : addr_mapped

   // Unmapped or misaligned accesses answer with an error.
   assign pslverr = psel && penable && !addr_mapped(paddr);

   // ---------------------------------------------------------------
   // Filter control writes.
   // ---------------------------------------------------------------
   // Each control word holds two filters; the pair index picks the group
   // and the half picks which two of the four in that group are touched.
   // The bus has no byte strobes, so software must always rewrite both
   // filters of a word together, keeping the neighbour's byte intact.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
            filter_ctrl[i] <= 8'h00;
      end
      else if (wr_en && in_ctrl && paddr[1:0] == 2'h0)
      begin
         // Reserved bits 6:5 are dropped so they read zero.
         filter_ctrl[{paddr[4:3], is_hi, 1'b0}] <=
            wdata16[7:0] & caf_pkg::CTL_MASK[7:0];
         filter_ctrl[{paddr[4:3], is_hi, 1'b1}] <=
            wdata16[15:8] & caf_pkg::CTL_MASK[15:8];
      end
   end

   // ---------------------------------------------------------------
   // Identifier object writes.
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
         begin
            fobj_hi[i] <= 16'h0000;
            fobj_lo[i] <= 16'h0000;
         end
      end
      else if (wr_en && in_fobj && paddr[1:0] == 2'h0)
      begin
         // Bit 15 of the high word is unimplemented.
         if (is_hi)
            fobj_hi[idx] <= wdata16 & caf_pkg::HI_MASK;
         else
            fobj_lo[idx] <= wdata16 & caf_pkg::LO_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Mask writes.
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
         begin
            mask_hi[i] <= 16'h0000;
            mask_lo[i] <= 16'h0000;
         end
      end
      else if (wr_en && in_mask && paddr[1:0] == 2'h0)
      begin
         // Bit 15 of the high word is unimplemented.
         if (is_hi)
            mask_hi[idx] <= wdata16 & caf_pkg::HI_MASK;
         else
            mask_lo[idx] <= wdata16 & caf_pkg::LO_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Mode register.
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         data_byte_mode <= 1'b0;
      else if (wr_en && paddr == caf_pkg::MODE_ADDR)
         data_byte_mode <= pwdata[0];
   end

   // ---------------------------------------------------------------
   // Read mux.
   // ---------------------------------------------------------------
   // Read data is registered on the setup cycle so that it stands
   // throughout the access phase.
   // The address is already valid in the setup cycle, so this costs no
   // latency and keeps the wide read mux off the output path.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         prdata <= 32'h0000_0000;
         if (paddr[1:0] != 2'h0)
            prdata <= 32'h0000_0000;
         else if (in_ctrl)
            prdata <= {16'h0000,
               filter_ctrl[{paddr[4:3], is_hi, 1'b1}],
               filter_ctrl[{paddr[4:3], is_hi, 1'b0}]};
         else if (in_fobj)
            prdata <= {16'h0000, is_hi ? fobj_hi[idx] : fobj_lo[idx]};
         else if (in_mask)
            prdata <= {16'h0000, is_hi ? mask_hi[idx] : mask_lo[idx]};
         else if (paddr == caf_pkg::MODE_ADDR)
            prdata <= {31'h0000_0000, data_byte_mode};
         else if (paddr == caf_pkg::STAT_ADDR)
            prdata <= {hit_count, 2'h0, accept_hit, accept_object,
               accept_filter, 4'h0};
      end
   end

   // ---------------------------------------------------------------
   // Match logic.
   // ---------------------------------------------------------------
   // The stored standard bit eleven is kept for software only and takes
   // no part in the compare, since the frame carries no such bit.
   // One filter against the incoming frame; masked-out bits never
   // block a hit.
   function automatic logic filter_match(input int n);
      logic [10:0] f_sid;
      logic [10:0] m_sid;
      logic [17:0] f_eid;
      logic [17:0] m_eid;
      logic sel;
      logic type_en;
      logic sid_ok;
      logic eid_ok;
      logic data_ok;
      logic type_ok;
      f_sid = fobj_lo[n][10:0];
      m_sid = mask_lo[n][10:0];
      f_eid = {fobj_hi[n][12:0], fobj_lo[n][15:11]};
      m_eid = {mask_hi[n][12:0], mask_lo[n][15:11]};
      sel = fobj_hi[n][caf_pkg::HI_SEL_BIT];
      type_en = mask_hi[n][caf_pkg::HI_SEL_BIT];
      sid_ok = ((f_sid ^ rx_standard_id) & m_sid) == 11'h000;
      eid_ok = ((f_eid ^ rx_extended_id) & m_eid) == 18'h00000;
      // Data-byte mode uses the upper sixteen extended bits as a
      // pattern for the first two data bytes.
      data_ok = ((f_eid[17:2] ^ rx_data_bytes) & m_eid[17:2]) == 16'h0000;
      // Type restriction only when the mask asks for it.
      type_ok = !type_en || (sel == rx_extended);
      if (data_byte_mode && !rx_extended)
         filter_match = type_ok && sid_ok && data_ok;
      else if (rx_extended)
         filter_match = type_ok && sid_ok && eid_ok;
      else
         filter_match = type_ok && sid_ok;
   endfunction : filter_match

   // Pointer codes zero and 11000 to 11111 act as a disabled filter,
   // so a misprogrammed filter can never steer a frame into the
   // transmit queue or into a reserved object.
   // Combined per-filter hit, enable and pointer validity applied.
   logic [15:0] hit_vec;

   always_comb
   begin
      for (int i = 0; i < caf_pkg::NUM_FILTERS; i++)
      begin
         // Disabled filters and reserved pointers never hit.
         hit_vec[i] = filter_ctrl[i][caf_pkg::CTL_EN_BIT] &&
            filter_ctrl[i][4:0] != 5'h00 &&
            filter_ctrl[i][4:3] != 2'h3 &&
            filter_match(i);
      end
   end

   // Lowest-numbered hitting filter wins.
   // Scanning from the top down lets the lowest index assign last, so
   // no priority chain has to be written out by hand.
   logic [3:0] next_filter;
   logic next_hit;

   always_comb
   begin
      next_filter = 4'h0;
      next_hit = 1'b0;
      for (int i = caf_pkg::NUM_FILTERS - 1; i >= 0; i--)
      begin
         if (hit_vec[i])
         begin
            next_filter = i[3:0];
            next_hit = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Result registers.
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         accept_valid <= 1'b0;
         accept_hit <= 1'b0;
         accept_object <= 5'h00;
         accept_filter <= 4'h0;
      end
      else
      begin
         // Only the strobe pulses; the result fields hold until the
         // next frame so a slow consumer may read them at leisure.
         accept_valid <= rx_valid;
         if (rx_valid)
         begin
            accept_hit <= next_hit;
            accept_filter <= next_filter;
            // Object number equals the pointer value.
            accept_object <= next_hit ?
               filter_ctrl[next_filter][4:0] : 5'h00;
         end
      end
   end

   // Accepted-frame counter, wraps silently.
   // It counts frames that hit any enabled filter, and software sees it
   // in the upper half of the status word.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         hit_count <= 16'h0000;
      else if (rx_valid && next_hit)
         hit_count <= hit_count + 16'h0001;
   end

endmodule : caf_filter

// ### caf_filter_props.sv
// ----
// Checker on the filter's ports.
// ----
module caf_filter_props
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic rx_valid,
   input wire logic accept_valid,
   input wire logic accept_hit,
   input wire logic [4:0] accept_object
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // Read access phase, when read data must be settled.
   wire rd_acc = psel && penable && !pwrite;
   AST_NEXT:
      assert property (rx_valid |=> accept_valid)
      else $error("no result after a frame");
   AST_PULSE:
      assert property (!rx_valid |=> !accept_valid)
      else $error("result without a frame");
   AST_HOLD:
      assert property (!rx_valid |=>
         $stable(accept_object) && $stable(accept_hit))
      else $error("result changed between frames");
   AST_MISS:
      assert property (accept_valid && !accept_hit |-> accept_object == 5'h00)
      else $error("object set on a miss");
   AST_NONZERO:
      assert property (accept_hit |-> accept_object != 5'h00)
      else $error("hit steered to object zero");
   AST_RSVD:
      assert property (accept_hit |-> accept_object < 5'h18)
      else $error("hit steered to a reserved object");
   AST_CTRL:
      assert property (rd_acc && paddr < 12'h020 |->
         (prdata & 32'hffff6060) == 0)
      else $error("control gap bits not zero");
   AST_HIGH:
      assert property (rd_acc && paddr >= 12'h040 && paddr < 12'h140
         && paddr[2] |-> prdata[31:15] == 0)
      else $error("high word bit 15 not zero");
   AST_REFUSE:
      assert property (rd_acc && paddr >= 12'h148 |-> pslverr && prdata == 0)
      else $error("unmapped read not refused");
   cover property (accept_valid && accept_hit);
   cover property (accept_valid && !accept_hit);
   cover property (psel && penable && pslverr);
endmodule : caf_filter_props

bind caf_filter caf_filter_props u_props (
   .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
   .rx_valid(rx_valid), .accept_valid(accept_valid),
   .accept_hit(accept_hit), .accept_object(accept_object));

// ### caf_rx_src.sv
// ----
// Protocol engine stand-in: one frame per call.
// ----
module caf_rx_src
(
   input wire logic sys_clk,
   output logic rx_valid,
   output logic rx_extended,
   output logic [10:0] rx_standard_id,
   output logic [17:0] rx_extended_id,
   output logic [15:0] rx_data_bytes
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      rx_valid = 1'b0;
      rx_extended = 1'b0;
      rx_standard_id = '0;
      rx_extended_id = '0;
      rx_data_bytes = '0;
   end
   // Fields are inverted once the strobe drops, so stale values never look
   // valid to a filter that samples outside the strobe.
   task send(input logic e, input logic [10:0] s, input logic [17:0] x,
      input logic [15:0] d);
      @(posedge sys_clk);
      rx_valid <= 1'b1;
      rx_extended <= e;
      rx_standard_id <= s;
      rx_extended_id <= x;
      rx_data_bytes <= d;
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      rx_extended <= ~e;
      rx_standard_id <= ~s;
      rx_extended_id <= ~x;
      rx_data_bytes <= ~d;
   endtask : send
endmodule : caf_rx_src

// ### caf_filter_tb_top.sv
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
   miscompares++; $display("unexpected %s exp %h got %h", n, e, s); end end
module caf_filter_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rx_valid, rx_extended, accept_valid, accept_hit, last_hit;
   logic [10:0] rx_standard_id;
   logic [17:0] rx_extended_id;
   logic [15:0] rx_data_bytes;
   logic [4:0] accept_object, last_obj;
   logic [3:0] accept_filter;
   // Model of every register word, indexed by byte address over four.
   logic [15:0] rg [0:81];
   int miscompares, n_checks, hits;
   caf_filter uut (.sys_clk(sys_clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_extended(rx_extended),
      .rx_standard_id(rx_standard_id), .rx_extended_id(rx_extended_id),
      .rx_data_bytes(rx_data_bytes), .accept_valid(accept_valid),
      .accept_hit(accept_hit), .accept_object(accept_object),
      .accept_filter(accept_filter));
   caf_rx_src src (.sys_clk(sys_clk), .rx_valid(rx_valid),
      .rx_extended(rx_extended), .rx_standard_id(rx_standard_id),
      .rx_extended_id(rx_extended_id), .rx_data_bytes(rx_data_bytes));
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // A hang counts as a failure.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      end_sim();
   end
   task end_sim;
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // One APB transfer; waits for pready, takes data at that edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Writable bits of each word.
   function automatic logic [15:0] wm(int i);
      if (i < 8) return 16'h9f9f;
      if (i == 80) return 16'h0001;
      return i[0] ? 16'h7fff : 16'hffff;
   endfunction : wm
   task rd_all;
      for (int i = 0; i < 81; i++)
         if (i < 8 || i > 15)
         begin
            apb(1'b0, 12'(i * 4), 32'h0);
            `CHK("reg", {16'h0, rg[i]}, rd)
         end
   endtask : rd_all
   // Small identifier values keep hits frequent; junk goes in gap bits.
   task cfg;
      logic [31:0] w;
      for (int i = 0; i < 80; i++)
         if (i < 8 || i > 15)
         begin
            w = $urandom;
            if (i < 8) w &= 32'hffffe7e7;
            else if (i < 48) w &= i[0] ? 32'hffffe000 : 32'hffff7803;
            apb(1'b1, 12'(i * 4), w);
            rg[i] = w[15:0] & wm(i);
         end
   endtask : cfg
   task frame;
      logic e, ok;
      logic [10:0] s, fs, ms;
      logic [17:0] x, fe, me;
      logic [15:0] d;
      logic [7:0] c;
      logic [3:0] fl;
      e = 1'($urandom);
      s = 11'($urandom % 4);
      x = 18'($urandom % 16);
      d = 16'($urandom % 4);
      last_hit = 1'b0;
      last_obj = 5'h00;
      fl = 4'h0;
      // Downward scan, so the lowest hitting filter is kept.
      for (int f = 15; f >= 0; f--)
      begin
         c = rg[f / 2][8 * (f % 2) +: 8];
         fs = rg[16 + 2 * f][10:0];
         ms = rg[48 + 2 * f][10:0];
         fe = {rg[17 + 2 * f][12:0], rg[16 + 2 * f][15:11]};
         me = {rg[49 + 2 * f][12:0], rg[48 + 2 * f][15:11]};
         ok = c[7] && c[4:0] != 0 && ((fs ^ s) & ms) == 0;
         if (e) ok &= ((fe ^ x) & me) == 0;
         else if (rg[80][0])
            ok &= ((fe[17:2] ^ d) & me[17:2]) == 0;
         if (rg[49 + 2 * f][14]) ok &= rg[17 + 2 * f][14] == e;
         if (ok)
         begin
            last_hit = 1'b1;
            last_obj = c[4:0];
            fl = 4'(f);
         end
      end
      hits += last_hit;
      src.send(e, s, x, d);
      #1;
      `CHK("valid", 1'b1, accept_valid)
      `CHK("hit", last_hit, accept_hit)
      `CHK("object", last_obj, accept_object)
      if (last_hit) `CHK("filter", fl, accept_filter)
   endtask : frame
   initial
   begin
      void'($urandom(52600));
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      foreach (rg[i]) rg[i] = 16'h0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      apb(1'b1, 12'h001, 32'hffffffff);
      `CHK("err", 1'b1, er)
      apb(1'b0, 12'h148, 32'h0);
      `CHK("err", 1'b1, er)
      `CHK("rdata", 32'h0, rd)
      rd_all();
      // Identifier mode first, then data-byte mode.
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, 12'h140, 32'(m));
         rg[80] = 16'(m);
         cfg();
         rd_all();
         repeat (150) frame();
      end
      apb(1'b0, 12'h144, 32'h0);
      `CHK("status", {16'(hits), 2'b0, last_hit, last_obj}, rd[31:8])
      end_sim();
   end
endmodule : caf_filter_tb_top
